// ---- vts_pkg.sv ----
package vts_pkg;

	// Clock period of the control logic
	localparam int unsigned SYS_CLK_PERIOD_NS = 20;

	// Time without carrier edges after which the tag counts as out of the field
	localparam int unsigned FIELD_LOSS_TIME_NS = 1000000;
	localparam int unsigned FIELD_LOSS_CYC = FIELD_LOSS_TIME_NS / SYS_CLK_PERIOD_NS;

	// Request flag positions
	localparam int unsigned FLG_INVENTORY = 2;
	localparam int unsigned FLG_SELECT = 4;
	localparam int unsigned FLG_ADDRESS = 5;

	// Response flags bytes
	localparam logic [7:0] RESP_FLAGS_OK = 8'h00;
	localparam logic [7:0] RESP_FLAGS_ERR = 8'h01;

	// Error codes
	localparam logic [7:0] ERR_MFG_CODE = 8'h01;
	localparam logic [7:0] ERR_FORMAT = 8'h02;
	localparam logic [7:0] ERR_FLAGS = 8'h03;
	localparam logic [7:0] ERR_UNSPEC = 8'h0f;
	localparam logic [7:0] ERR_NO_DATA = 8'h10;
	localparam logic [7:0] ERR_ALREADY_LOCKED = 8'h11;
	localparam logic [7:0] ERR_LOCKED = 8'h12;
	localparam logic [7:0] ERR_PROG_FAIL = 8'h13;
	localparam logic [7:0] ERR_LOCK_FAIL = 8'h14;
	localparam logic [7:0] ERR_READ_PROT = 8'h15;

	// Command opcodes the state logic needs to recognise
	localparam logic [7:0] OP_INVENTORY = 8'h01;
	localparam logic [7:0] OP_STAY_QUIET = 8'h02;
	localparam logic [7:0] OP_READ_SINGLE = 8'h20;
	localparam logic [7:0] OP_SELECT = 8'h25;
	localparam logic [7:0] OP_RESET_READY = 8'h26;
	localparam logic [7:0] OP_CONFIG_READ = 8'ha0;
	localparam logic [7:0] OP_KILL = 8'ha6;
	localparam logic [7:0] OP_RANDOM = 8'hb4;
	localparam logic [7:0] OP_PRIVACY_TOGGLE = 8'hba;

	// Configuration read that returns the true identifier, except in the untraceable state where it is refused
	localparam logic [7:0] TRUE_UID_FID = 8'hfe;
	localparam logic [7:0] TRUE_UID_PID = 8'h01;
	localparam logic [7:0] BLOCK_ZERO = 8'h00;
	localparam logic [7:0] MASKED_ID_BYTE = 8'h00;

	// Privacy default field encodings
	localparam logic [1:0] PRIV_DFT_ALWAYS = 2'b01;
	localparam logic [1:0] PRIV_DFT_LOOP_CLOSED = 2'b10;
	localparam logic [1:0] PRIV_DFT_LOOP_OPEN = 2'b11;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_UID_LO = 8'h04;
	localparam logic [7:0] REG_UID_HI = 8'h08;
	localparam logic [7:0] REG_IDENT = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// Control register fields
	localparam int unsigned CTRL_KILL = 0;
	localparam int unsigned CTRL_PRIV_CMD = 1;
	localparam int unsigned CTRL_PRIV_DFT_LSB = 2;
	localparam int unsigned CTRL_INV_DIS = 4;

	// Reset values
	localparam logic [63:0] UID_RESET = 64'h0;
	localparam logic [7:0] AFI_RESET = 8'h00;
	localparam logic [7:0] DSFID_RESET = 8'h00;

	// Protocol states, Gray coded along the usual path
	typedef enum logic [2:0] {
		ST_POWER_OFF = 3'b000,
		ST_READY = 3'b001,
		ST_SELECTED = 3'b011,
		ST_QUIET = 3'b010,
		ST_UNTRACEABLE = 3'b110,
		ST_DEACTIVATED = 3'b111
	} vts_state_t;

	// Decoded request from the frame decoder
	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] opcode;
		logic [63:0] uid;
		logic [7:0] block;
		logic [7:0] fid;
		logic [7:0] pid;
	} vts_req_t;

	// Response header handed to the frame encoder
	typedef struct packed {
		logic send;
		logic [7:0] flags;
		logic [7:0] code;
	} vts_resp_t;

	// True when a code is one of the defined error codes
	function automatic logic err_code_known(input logic [7:0] code);
		err_code_known = (code == ERR_MFG_CODE) || (code == ERR_FORMAT) ||
			(code == ERR_FLAGS) || (code == ERR_UNSPEC) ||
			((code >= ERR_NO_DATA) && (code <= ERR_READ_PROT));
	endfunction : err_code_known

endpackage : vts_pkg

// ---- vts_state_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Error reply: flags 01h, code, CRC
// - No error reply for inventory or broadcast
// - Protocol errors 01h 02h 03h 0Fh
// - Data errors 10h through 15h
// - Addressed requests need a UID match
// - Select mode answered only when SELECTED
// - Broadcast requests answered in READY and SELECTED; QUIET takes only reset to ready, untraceable only a few
// - Power-off without field, boot on field
// - READY ignores select mode requests
// - QUIET takes addressed and broadcast reset
// - SELECTED takes every addressing mode
// - Untraceable accepts only a few requests
// - Deactivated state ignores all requests
// - Boot untraceable on privacy bit conditions
// - Boot deactivated when kill setting set
// - Broadcast toggle leaves untraceable, clears bit
// - Addressed toggle enters untraceable, sets bit
// - Addressed kill deactivates tag permanently
// - Boot untraceable masks UID until power-off
// - Command untraceable masks UID while there
// - AFI and DSFID read 00h while untraceable
// - Masked values used for matching
// - Select plus address flags ignored
// - Select command enters SELECTED
// - Stay quiet command enters QUIET
module vts_state_ctrl #(
	parameter int unsigned FIELD_LOSS_CYC = vts_pkg::FIELD_LOSS_CYC,
	parameter logic [63:0] MASKED_UID = 64'h0123_4567_89ab_cdef // Arbitrary value
) (
	input wire logic sys_clk,
	input wire logic nrst,
	// Carrier clock recovered from the field, asynchronous
	input wire logic field_clk,
	// Tamper loop level, asynchronous, high when closed
	input wire logic tamper_closed,
	// Decoded request, one-cycle strobe
	input wire logic req_valid,
	input wire vts_pkg::vts_req_t req,
	// Result of command processing, one-cycle strobe
	input wire logic res_valid,
	input wire logic res_ok,
	input wire logic [7:0] res_code,
	// Go strobe to the command processor
	output logic proc_go,
	// Response header strobe to the encoder
	output logic resp_valid,
	output vts_pkg::vts_resp_t resp,
	// Identity values as presented to the reader
	output logic [63:0] uid_out,
	output logic [7:0] afi_out,
	output logic [7:0] dsfid_out,
	output vts_pkg::vts_state_t state_out,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr
);

	vts_pkg::vts_state_t state; // Protocol state
	logic [2:0] field_sync; // Carrier synchroniser plus edge history
	logic [1:0] tamper_sync; // Tamper loop synchroniser
	logic [23:0] loss_cnt; // Cycles since last carrier edge
	logic field_on; // Enough energy seen
	logic kill_setting; // Permanent deactivation bit
	logic privacy_command_bit; // Untraceable requested by command
	logic [1:0] privacy_default_field; // Untraceable default policy
	logic inventory_disable_setting; // Inventory refused while untraceable
	logic inv_dis_boot; // Inventory disable caught at boot
	logic boot_masked; // Booted untraceable, mask until power-off
	logic [63:0] uid; // True identifier
	logic [7:0] afi; // Application family identifier
	logic [7:0] dsfid; // Storage format identifier
	logic busy; // Request handed out, waiting for the result
	logic pend_silent; // Failure stays silent
	logic pend_addr; // Pending request was addressed
	logic pend_nonaddr; // Pending request was broadcast
	logic [7:0] pend_op; // Pending opcode
	logic pend_true_uid; // Pending config read wants the real UID

	// Request decode
	logic f_inv, f_sel, f_adr, f_non;
	logic masking, uid_hit, accept, drop_select;
	logic [63:0] eff_uid;
	logic carrier_edge, boot_untr, apb_acc, apb_wr;
	logic hw_priv_set, hw_priv_clr, hw_kill_set;

	// Carrier edges from the synced stages
	assign carrier_edge = field_sync[1] ^ field_sync[2];
	assign f_inv = req.flags[vts_pkg::FLG_INVENTORY];
	assign f_sel = req.flags[vts_pkg::FLG_SELECT] & ~f_inv;
	assign f_adr = req.flags[vts_pkg::FLG_ADDRESS] & ~f_inv;
	assign f_non = ~f_inv & ~f_sel & ~f_adr; // Answered in READY and SELECTED; QUIET takes only reset to ready, untraceable only a few opcodes
	assign masking = boot_masked | (state == vts_pkg::ST_UNTRACEABLE);
	assign eff_uid = masking ? MASKED_UID : uid;
	assign uid_hit = (req.uid == eff_uid); // Compared against masked UID while masking, else true UID
	assign apb_acc = psel & penable & pready;
	assign apb_wr = apb_acc & pwrite;

	// Privacy policy asks for an untraceable boot
	assign boot_untr = privacy_command_bit |
		(privacy_default_field == vts_pkg::PRIV_DFT_ALWAYS) |
		((privacy_default_field == vts_pkg::PRIV_DFT_LOOP_CLOSED) & tamper_sync[1]) |
		((privacy_default_field == vts_pkg::PRIV_DFT_LOOP_OPEN) & ~tamper_sync[1]);

	// Acceptance of a request in the current state
	always_comb begin
		accept = 1'b0;
		if (req_valid && !busy && !(req.flags[vts_pkg::FLG_SELECT] &&
			req.flags[vts_pkg::FLG_ADDRESS] && !f_inv)) begin // Invalid combination
			case (state)
				vts_pkg::ST_READY: begin
					accept = ~f_sel & (~f_adr | uid_hit);
				end
				vts_pkg::ST_SELECTED: begin
					accept = ~f_adr | uid_hit;
				end
				vts_pkg::ST_QUIET: begin
					accept = (f_adr & uid_hit) |
						(f_non & (req.opcode == vts_pkg::OP_RESET_READY));
				end
				vts_pkg::ST_UNTRACEABLE: begin
					accept = (f_non & ((req.opcode == vts_pkg::OP_RANDOM) |
						(req.opcode == vts_pkg::OP_PRIVACY_TOGGLE))) |
						(~inv_dis_boot & f_inv & (req.opcode == vts_pkg::OP_INVENTORY)) |
						(~inv_dis_boot & f_adr & uid_hit &
						(req.opcode == vts_pkg::OP_READ_SINGLE) &
						(req.block == vts_pkg::BLOCK_ZERO));
				end
				// Deactivated and power-off take nothing
				default: begin
					accept = 1'b0;
				end
			endcase
		end
	end

	// Another tag is being selected: this one steps back
	assign drop_select = req_valid && !busy && (state == vts_pkg::ST_SELECTED) && f_adr &&
		!req.flags[vts_pkg::FLG_SELECT] && (req.opcode == vts_pkg::OP_SELECT) && !uid_hit;

	// Privacy and kill bit updates on success
	assign hw_priv_clr = res_valid & busy & res_ok & pend_nonaddr &
		(pend_op == vts_pkg::OP_PRIVACY_TOGGLE) & (state == vts_pkg::ST_UNTRACEABLE);
	assign hw_priv_set = res_valid & busy & res_ok & pend_addr &
		(pend_op == vts_pkg::OP_PRIVACY_TOGGLE) & (state != vts_pkg::ST_UNTRACEABLE);
	assign hw_kill_set = res_valid & busy & res_ok & pend_addr &
		(pend_op == vts_pkg::OP_KILL) & (state != vts_pkg::ST_UNTRACEABLE);

	// Input synchronisers
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			field_sync <= 3'b000;
			tamper_sync <= 2'b00;
		end else begin
			field_sync <= {field_sync[1:0], field_clk};
			tamper_sync <= {tamper_sync[0], tamper_closed};
		end
	end

	// Field presence: carrier edges keep it alive, silence drops it
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			loss_cnt <= 24'h000000;
			field_on <= 1'b0;
		end else if (carrier_edge) begin
			loss_cnt <= 24'h000000;
			field_on <= 1'b1;
		end else if (loss_cnt >= FIELD_LOSS_CYC[23:0] - 24'h000001) begin
			field_on <= 1'b0;
		end else begin
			loss_cnt <= loss_cnt + 24'h000001;
		end
	end

	// Protocol state machine
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state <= vts_pkg::ST_POWER_OFF;
		end else if (!field_on) begin
			state <= vts_pkg::ST_POWER_OFF;
		end else begin
			case (state)
				vts_pkg::ST_POWER_OFF: begin
					if (kill_setting) begin
						state <= vts_pkg::ST_DEACTIVATED;
					end else if (boot_untr) begin
						state <= vts_pkg::ST_UNTRACEABLE;
					end else begin
						state <= vts_pkg::ST_READY;
					end
				end
				vts_pkg::ST_DEACTIVATED: begin
					state <= vts_pkg::ST_DEACTIVATED;
				end
				vts_pkg::ST_UNTRACEABLE: begin
					if (hw_priv_clr) begin
						state <= vts_pkg::ST_READY;
					end
				end
				default: begin
					if (drop_select) begin
						state <= vts_pkg::ST_READY;
					end else if (res_valid && busy && res_ok) begin
						if (hw_kill_set) begin
							state <= vts_pkg::ST_DEACTIVATED;
						end else if (hw_priv_set) begin
							state <= vts_pkg::ST_UNTRACEABLE;
						end else if (pend_op == vts_pkg::OP_SELECT) begin
							state <= vts_pkg::ST_SELECTED;
						end else if (pend_op == vts_pkg::OP_STAY_QUIET) begin
							state <= vts_pkg::ST_QUIET;
						end else if (pend_op == vts_pkg::OP_RESET_READY) begin
							state <= vts_pkg::ST_READY;
						end
					end
				end
			endcase
		end
	end

	// Boot-time captures: inventory disable and the sticky mask
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			inv_dis_boot <= 1'b0;
			boot_masked <= 1'b0;
		end else if (state == vts_pkg::ST_POWER_OFF) begin
			inv_dis_boot <= inventory_disable_setting;
			boot_masked <= field_on & ~kill_setting & boot_untr;
		end
	end

	// Pending request bookkeeping and go strobe
	always_ff @(posedge sys_clk) begin
		if (!nrst || !field_on) begin
			busy <= 1'b0;
			proc_go <= 1'b0;
			pend_silent <= 1'b0;
			pend_addr <= 1'b0;
			pend_nonaddr <= 1'b0;
			pend_op <= 8'h00;
			pend_true_uid <= 1'b0;
		end else begin
			proc_go <= accept;
			if (accept) begin
				busy <= 1'b1;
				pend_silent <= f_inv | f_non;
				pend_addr <= f_adr;
				pend_nonaddr <= f_non;
				pend_op <= req.opcode;
				pend_true_uid <= (req.opcode == vts_pkg::OP_CONFIG_READ) &&
					(req.fid == vts_pkg::TRUE_UID_FID) && (req.pid == vts_pkg::TRUE_UID_PID);
			end else if (res_valid) begin
				busy <= 1'b0;
				pend_true_uid <= 1'b0;
			end
		end
	end

	// Response header: success, formatted error, or silence
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			resp_valid <= 1'b0;
			resp <= '0;
		end else begin
			resp_valid <= res_valid & busy;
			if (res_valid && busy) begin
				if (res_ok) begin
					resp.send <= 1'b1;
					resp.flags <= vts_pkg::RESP_FLAGS_OK;
					resp.code <= 8'h00;
				end else begin
					resp.send <= ~pend_silent;
					resp.flags <= vts_pkg::RESP_FLAGS_ERR;
					// Unknown codes are reserved, so report them as unspecified
					resp.code <= vts_pkg::err_code_known(res_code) ? res_code :
						vts_pkg::ERR_UNSPEC;
				end
			end
		end
	end

	// Presented identity; masked while untraceable
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			uid_out <= vts_pkg::UID_RESET;
			afi_out <= vts_pkg::AFI_RESET;
			dsfid_out <= vts_pkg::DSFID_RESET;
			state_out <= vts_pkg::ST_POWER_OFF;
		end else begin
			uid_out <= (pend_true_uid && busy) ? uid : eff_uid;
			afi_out <= (state == vts_pkg::ST_UNTRACEABLE) ? vts_pkg::MASKED_ID_BYTE : afi;
			dsfid_out <= (state == vts_pkg::ST_UNTRACEABLE) ? vts_pkg::MASKED_ID_BYTE : dsfid;
			state_out <= state;
		end
	end

	// Nonvolatile control bits; hardware updates win over a bus write
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			kill_setting <= 1'b0;
			privacy_command_bit <= 1'b0;
			privacy_default_field <= 2'b00;
			inventory_disable_setting <= 1'b0;
		end else begin
			// Kill can only be set here; only reset clears it
			if (hw_kill_set || (apb_wr && paddr == vts_pkg::REG_CTRL &&
				pwdata[vts_pkg::CTRL_KILL])) begin
				kill_setting <= 1'b1;
			end
			if (hw_priv_set) begin
				privacy_command_bit <= 1'b1;
			end else if (hw_priv_clr) begin
				privacy_command_bit <= 1'b0;
			end else if (apb_wr && paddr == vts_pkg::REG_CTRL) begin
				privacy_command_bit <= pwdata[vts_pkg::CTRL_PRIV_CMD];
			end
			if (apb_wr && paddr == vts_pkg::REG_CTRL) begin
				privacy_default_field <= pwdata[vts_pkg::CTRL_PRIV_DFT_LSB +: 2];
				inventory_disable_setting <= pwdata[vts_pkg::CTRL_INV_DIS];
			end
		end
	end

	// Identity registers written by software
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			uid <= vts_pkg::UID_RESET;
			afi <= vts_pkg::AFI_RESET;
			dsfid <= vts_pkg::DSFID_RESET;
		end else if (apb_wr) begin
			case (paddr)
				vts_pkg::REG_UID_LO: begin
					uid[31:0] <= pwdata;
				end
				vts_pkg::REG_UID_HI: begin
					uid[63:32] <= pwdata;
				end
				vts_pkg::REG_IDENT: begin
					afi <= pwdata[7:0];
					dsfid <= pwdata[15:8];
				end
				default: begin
				end
			endcase
		end
	end

	// APB slave: one wait state, data and error registered with ready
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			case (paddr)
				vts_pkg::REG_CTRL: begin
					if (!pwrite) begin
						prdata <= {27'h0000000, inventory_disable_setting,
							privacy_default_field, privacy_command_bit, kill_setting};
					end
				end
				vts_pkg::REG_UID_LO: begin
					if (!pwrite) begin
						prdata <= uid[31:0];
					end
				end
				vts_pkg::REG_UID_HI: begin
					if (!pwrite) begin
						prdata <= uid[63:32];
					end
				end
				vts_pkg::REG_IDENT: begin
					if (!pwrite) begin
						prdata <= {16'h0000, dsfid, afi};
					end
				end
				vts_pkg::REG_STATUS: begin
					// Read-only view of the protocol state
					if (!pwrite) begin
						prdata <= {25'h0000000, busy, masking, field_on, 1'b0, state};
					end else begin
						pslverr <= 1'b1;
					end
				end
				default: begin
					pslverr <= 1'b1; // Unmapped address
				end
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule : vts_state_ctrl

`default_nettype wire

// ---- vts_state_ctrl_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the tag state and reply logic
module vts_state_ctrl_assertions #(
	parameter int unsigned FIELD_LOSS_CYC = vts_pkg::FIELD_LOSS_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic req_valid,
	input wire vts_pkg::vts_req_t req,
	input wire logic res_valid,
	input wire logic proc_go,
	input wire logic resp_valid,
	input wire vts_pkg::vts_resp_t resp,
	input wire logic [63:0] uid_out,
	input wire logic [7:0] afi_out,
	input wire logic [7:0] dsfid_out,
	input wire vts_pkg::vts_state_t state_out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic busy; // A request is in flight
	logic [7:0] op_q; // Opcode of the last offered request
	logic quiet_q; // Its failure must stay silent
	// Request in flight
	always_ff @(posedge sys_clk) begin
		if (!nrst || res_valid) begin
			busy <= 1'b0;
		end else if (proc_go) begin
			busy <= 1'b1;
		end
	end
	// Latch the offered request
	always_ff @(posedge sys_clk) begin
		if (req_valid && !busy) begin
			op_q <= req.opcode;
			quiet_q <= req.flags[2] || (req.flags[5:4] == 2'b00);
		end
	end
	// Command done with success
	sequence s_done_ok(logic [7:0] op);
		resp_valid && resp.flags == vts_pkg::RESP_FLAGS_OK && op_q == op;
	endsequence
	chk_err_flags: assert property (
		resp_valid && resp.code != 8'h00 |-> resp.flags == vts_pkg::RESP_FLAGS_ERR)
		else $error("error flags");
	chk_err_code: assert property (
		resp_valid && resp.flags == vts_pkg::RESP_FLAGS_ERR
		|-> resp.code inside {8'h01, 8'h02, 8'h03, 8'h0f, [8'h10:8'h15]})
		else $error("reserved code");
	chk_quiet_err: assert property (
		resp_valid && resp.flags == vts_pkg::RESP_FLAGS_ERR && quiet_q |-> !resp.send)
		else $error("error reply not silent");
	chk_sel_addr: assert property (
		req_valid && !req.flags[2] && req.flags[5:4] == 2'b11 |=> !proc_go)
		else $error("invalid flags taken");
	chk_deactivated_state_deaf: assert property (
		state_out == vts_pkg::ST_DEACTIVATED && req_valid |=> !proc_go)
		else $error("deactivated tag answered");
	chk_ready_sel: assert property (
		state_out == vts_pkg::ST_READY && !resp_valid && req_valid && !req.flags[2]
		&& req.flags[5:4] == 2'b01 |=> !proc_go)
		else $error("select taken in ready");
	chk_quiet_inv: assert property (
		state_out == vts_pkg::ST_QUIET && !resp_valid && req_valid && req.flags[2] |=> !proc_go)
		else $error("inventory taken in quiet");
	chk_sel_any: assert property (
		state_out == vts_pkg::ST_SELECTED && !resp_valid && !busy && req_valid
		&& !req.flags[2] && req.flags[5:4] == 2'b01 |=> proc_go)
		else $error("select refused in selected");
	chk_addr_miss: assert property (
		req_valid && !resp_valid && !req.flags[2] && req.flags[5:4] == 2'b10
		&& req.uid != uid_out |=> !proc_go)
		else $error("foreign UID taken");
	chk_kill_enter: assert property (
		s_done_ok(vts_pkg::OP_KILL) |=> state_out == vts_pkg::ST_DEACTIVATED)
		else $error("kill did not deactivate");
	chk_select_enter: assert property (
		s_done_ok(vts_pkg::OP_SELECT) |=> state_out == vts_pkg::ST_SELECTED)
		else $error("select failed");
	chk_quiet_enter: assert property (
		s_done_ok(vts_pkg::OP_STAY_QUIET) |=> state_out == vts_pkg::ST_QUIET)
		else $error("stay quiet failed");
	chk_id_masked: assert property (
		state_out == vts_pkg::ST_UNTRACEABLE && $past(state_out) == vts_pkg::ST_UNTRACEABLE
		|-> afi_out == 8'h00 && dsfid_out == 8'h00)
		else $error("AFI or DSFID not masked");
endmodule : vts_state_ctrl_assertions
`default_nettype wire

// ---- vts_cmd_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Field carrier and command processor standing behind the state logic
module vts_cmd_model (
	input wire logic sys_clk,
	input wire logic field_en, // Tag sits in a reader field
	input wire logic proc_go,
	input wire logic [7:0] fail_code, // 00h means success
	input wire logic [3:0] dly, // Cycles from go to result
	output logic field_clk,
	output logic res_valid,
	output logic res_ok,
	output logic [7:0] res_code
);
	// Carrier halts outside the field; offset keeps edges off sys_clk
	initial begin
		field_clk = 1'b0;
		#7;
		forever #80 if (field_en) field_clk = ~field_clk;
	end
	// One result per go; result lines show garbage outside the strobe
	initial begin
		res_valid = 1'b0;
		res_ok = 1'b0;
		res_code = 8'h5a;
		forever begin
			@(posedge sys_clk);
			if (proc_go) begin
				repeat (dly) @(posedge sys_clk);
				res_valid <= 1'b1;
				res_ok <= (fail_code == 8'h00);
				res_code <= fail_code;
				@(posedge sys_clk);
				res_valid <= 1'b0;
				res_ok <= ~res_ok;
				res_code <= ~fail_code;
			end
		end
	end
endmodule : vts_cmd_model
`default_nettype wire

// ---- vts_state_ctrl_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module vts_state_ctrl_tb;
	localparam int unsigned LOSS = 200; // Short field loss time
	localparam logic [63:0] MUID = 64'h0123_4567_89ab_cdef; // Arbitrary masked identifier
	localparam logic [63:0] TUID = 64'hfeed_0001_c0de_0042; // Arbitrary own identifier
	localparam logic [63:0] XUID = 64'hfeed_0001_c0de_0043; // Another tag
	localparam logic [7:0] BC = 8'h00, SE = 8'h10, AD = 8'h20, IV = 8'h04; // Request flags
	localparam logic [7:0] RSB = vts_pkg::OP_READ_SINGLE, INV = vts_pkg::OP_INVENTORY,
		RND = vts_pkg::OP_RANDOM, TGL = vts_pkg::OP_PRIVACY_TOGGLE, KIL = vts_pkg::OP_KILL;
	localparam vts_pkg::vts_state_t RDY = vts_pkg::ST_READY, UNT = vts_pkg::ST_UNTRACEABLE,
		DEA = vts_pkg::ST_DEACTIVATED, SLD = vts_pkg::ST_SELECTED, QUI = vts_pkg::ST_QUIET;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic field_en = 1'b0;
	logic tamper_closed = 1'b0;
	logic req_valid = 1'b0;
	vts_pkg::vts_req_t req = '0;
	logic [7:0] fail_code = 8'h00;
	logic [3:0] dly = 4'd1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic field_clk, res_valid, res_ok, proc_go, resp_valid, pready, pslverr, got_go;
	logic [7:0] res_code, afi_out, dsfid_out;
	vts_pkg::vts_resp_t resp;
	vts_pkg::vts_state_t state_out;
	logic [63:0] uid_out, uid_busy;
	logic [7:0] codes [11] = '{8'h01, 8'h02, 8'h03, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13,
		8'h14, 8'h15, 8'h20};
	logic [31:0] bctl [6] = '{32'h02, 32'h04, 32'h08, 32'h08, 32'h0c, 32'h0c};
	logic btmp [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
	vts_pkg::vts_state_t bst [6] = '{UNT, UNT, UNT, RDY, UNT, RDY};
	int fails = 0, cmp_count = 0, cyc = 0;
	vts_state_ctrl #(.FIELD_LOSS_CYC(LOSS), .MASKED_UID(MUID)) u_dut (.sys_clk, .nrst,
		.field_clk, .tamper_closed, .req_valid, .req, .res_valid, .res_ok, .res_code,
		.proc_go, .resp_valid, .resp, .uid_out, .afi_out, .dsfid_out, .state_out, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
	vts_cmd_model u_model (.sys_clk, .field_en, .proc_go, .fail_code, .dly, .field_clk,
		.res_valid, .res_ok, .res_code);
	// Free-running system clock
	always #10 sys_clk = ~sys_clk;
	// Hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end
	// Compare and count
	task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer; the slave's wait states are not assumed
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic err);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		chk(pslverr, err);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Offer a request; check go and state
	task automatic xfer(input logic [7:0] fl, input logic [7:0] op, input logic [63:0] u,
		input logic eg, input vts_pkg::vts_state_t est, input logic [7:0] fc = 8'h00,
		input logic [7:0] arg = 8'h00);
		int n;
		n = 0;
		@(posedge sys_clk);
		fail_code <= fc;
		req_valid <= 1'b1;
		req <= '{flags: fl, opcode: op, uid: u, block: arg, fid: arg, pid: 8'h01};
		@(posedge sys_clk);
		req_valid <= 1'b0;
		@(posedge sys_clk);
		got_go = proc_go;
		while (got_go && resp_valid !== 1'b1 && n < 30) begin
			@(posedge sys_clk);
			n++;
			if (n == 1) uid_busy = uid_out;
		end
		@(posedge sys_clk);
		chk({got_go, state_out}, {eg, est});
	endtask : xfer
	// Field off, configure, field on, check boot
	task automatic boot(input logic [31:0] ctl, input logic tc, input vts_pkg::vts_state_t est);
		@(posedge sys_clk);
		field_en <= 1'b0;
		repeat (LOSS + 20) @(posedge sys_clk);
		chk(state_out, vts_pkg::ST_POWER_OFF);
		apb(1'b1, vts_pkg::REG_CTRL, ctl, 1'b0);
		tamper_closed <= tc;
		field_en <= 1'b1;
		repeat (30) @(posedge sys_clk);
		chk(state_out, est);
	endtask : boot
	// Single place where the run ends
	task automatic conclude();
		$display("Compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	// Main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		apb(1'b1, vts_pkg::REG_UID_LO, TUID[31:0], 1'b0);
		apb(1'b1, vts_pkg::REG_UID_HI, TUID[63:32], 1'b0);
		apb(1'b1, vts_pkg::REG_IDENT, 32'h0000_a5c3, 1'b0);
		apb(1'b0, 8'h14, 32'h0, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, vts_pkg::REG_STATUS, 32'h7, 1'b1);
		apb(1'b0, vts_pkg::REG_UID_HI, 32'h0, 1'b0);
		chk(rd, TUID[63:32]);
		boot(32'h0, 1'b0, RDY);
		chk({afi_out, dsfid_out}, 16'hc3a5);
		xfer(SE, RSB, 64'h0, 1'b0, RDY);
		xfer(8'h30, RSB, TUID, 1'b0, RDY);
		xfer(AD, RSB, XUID, 1'b0, RDY);
		xfer(IV, INV, 64'h0, 1'b1, RDY, 8'h0f);
		chk(resp.send, 1'b0);
		xfer(BC, RSB, 64'h0, 1'b1, RDY, 8'h12);
		chk(resp.send, 1'b0);
		for (int i = 0; i < 11; i++) begin
			dly <= i[0] ? 4'd6 : 4'd1;
			xfer(AD, RSB, TUID, 1'b1, RDY, codes[i]);
			chk({resp.send, resp.flags, resp.code}, {1'b1, 8'h01, i == 10 ? 8'h0f : codes[i]});
		end
		xfer(AD, vts_pkg::OP_SELECT, TUID, 1'b1, SLD);
		xfer(SE, RSB, 64'h0, 1'b1, SLD);
		xfer(IV, INV, 64'h0, 1'b1, SLD);
		xfer(BC, RND, 64'h0, 1'b1, SLD);
		xfer(AD, vts_pkg::OP_SELECT, XUID, 1'b0, RDY);
		xfer(AD, vts_pkg::OP_STAY_QUIET, TUID, 1'b1, QUI);
		xfer(IV, INV, 64'h0, 1'b0, QUI);
		xfer(BC, RND, 64'h0, 1'b0, QUI);
		xfer(SE, RSB, 64'h0, 1'b0, QUI);
		xfer(AD, RSB, TUID, 1'b1, QUI);
		xfer(BC, vts_pkg::OP_RESET_READY, 64'h0, 1'b1, RDY);
		xfer(AD, TGL, TUID, 1'b1, UNT);
		chk({uid_out, afi_out, dsfid_out}, {MUID, 16'h0});
		apb(1'b0, vts_pkg::REG_CTRL, 32'h0, 1'b0);
		chk(rd[1], 1'b1);
		xfer(AD, RSB, MUID, 1'b0, UNT, 8'h00, 8'h01);
		xfer(AD, RSB, MUID, 1'b1, UNT);
		xfer(BC, RSB, 64'h0, 1'b0, UNT);
		xfer(IV, INV, 64'h0, 1'b1, UNT);
		xfer(AD, KIL, MUID, 1'b0, UNT);
		xfer(BC, RND, 64'h0, 1'b1, UNT);
		xfer(BC, TGL, 64'h0, 1'b1, RDY);
		chk(uid_out, TUID);
		apb(1'b0, vts_pkg::REG_CTRL, 32'h0, 1'b0);
		chk(rd[1], 1'b0);
		for (int i = 0; i < 6; i++) begin
			boot(bctl[i], btmp[i], bst[i]);
		end
		boot(32'h14, 1'b0, UNT);
		chk(uid_out, MUID);
		xfer(IV, INV, 64'h0, 1'b0, UNT);
		xfer(BC, TGL, 64'h0, 1'b1, RDY);
		chk(uid_out, MUID);
		dly <= 4'd6;
		xfer(AD, vts_pkg::OP_CONFIG_READ, MUID, 1'b1, RDY, 8'h00, 8'hfe);
		chk(uid_busy, TUID);
		xfer(AD, RSB, TUID, 1'b0, RDY);
		xfer(AD, KIL, MUID, 1'b1, DEA);
		xfer(BC, RND, 64'h0, 1'b0, DEA);
		xfer(AD, TGL, MUID, 1'b0, DEA);
		boot(32'h0, 1'b0, DEA);
		conclude();
	end
endmodule : vts_state_ctrl_tb
bind vts_state_ctrl vts_state_ctrl_assertions #(.FIELD_LOSS_CYC(FIELD_LOSS_CYC)) u_chk (
	.sys_clk, .nrst, .req_valid, .req, .res_valid, .proc_go, .resp_valid, .resp,
	.uid_out, .afi_out, .dsfid_out, .state_out);
`default_nettype wire
